// ==== tmw_map.vh ====
// register offsets, field positions and reset values of the 8-bit timer
`ifndef TMW_MAP_VH
`define TMW_MAP_VH
`define TMW_ADDR_W 4
`define TMW_OFF_CTRL 4'h0
`define TMW_OFF_COUNT 4'h1
`define TMW_OFF_CMP 4'h2
`define TMW_OFF_PORT 4'h3
`define TMW_OFF_STAT 4'h4
`define TMW_BIT_FORCE 7
`define TMW_BIT_WGM0 6
`define TMW_BIT_COM1 5
`define TMW_BIT_COM0 4
`define TMW_BIT_WGM1 3
`define TMW_BIT_CS2 2
`define TMW_BIT_CS0 0
`define TMW_BIT_ASYNC 0
`define TMW_BIT_DIR 1
`define TMW_CTRL_RST 8'h00
`define TMW_TOP_MAX 8'hff
`define TMW_BOTTOM 8'h00
`define TMW_MODE_NORMAL 2'h0
`define TMW_MODE_PCPWM 2'h1
`define TMW_MODE_CTC 2'h2
`define TMW_MODE_FPWM 2'h3
`define TMW_PRESC_W 10
`define TMW_LOG_DIV8 4'd3
`define TMW_LOG_DIV32 4'd5
`define TMW_LOG_DIV64 4'd6
`define TMW_LOG_DIV128 4'd7
`define TMW_LOG_DIV256 4'd8
`define TMW_LOG_DIV1024 4'd10
`endif

// ==== tmw_timer8.v ====
// 8-bit timer/counter with one compare channel and waveform output
//
// Contract
// - force strobe in non-pwm mode applies the selected compare action now
// - forced compare sets no flag and never clears the counter
// - force strobe bit always reads back as zero
// - force strobe ignored in both pwm modes
// - mode bits 6 and 3: 0 normal,1 phase pwm,2 clear-on-match,3 fast pwm
// - top is 0xff, except compare value in clear-on-match mode
// - compare updates immediate or at top; overflow at max or bottom
// - nonzero output mode takes the pin, driven only if direction is out
// - non-pwm modes: 0 off, 1 toggle, 2 clear, 3 set on match
// - fast pwm: 2 clear on match set at top, 3 inverse, 1 reserved
// - phase pwm: 2 clear up-match set down-match, 3 inverse, 1 reserved
// - pwm with compare equal top and upper bit set: only top action
// - prescale select: stop, /1, /8, /32, /64, /128, /256, /1024
// - counter register gives direct read and write of the count
// - counter write suppresses compare match on next timer clock
// - compare value checked against counter on each count
// - fast pwm counts to max then wraps to zero
// - phase pwm counts up to max, turns there without a hold, counts down
// - prescaler source is i/o clock or async clock input
//
// Design decisions made here: the placing of the registers and strobed register access.
`include "tmw_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tmw_timer8 #(
    parameter PRESC_W = `TMW_PRESC_W
) (
    input wire clk_i,
    input wire arst_n_i,
    input wire async_clk_i,
    input wire [`TMW_ADDR_W-1:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire port_data_i,
    output reg compare_out_pin_o,
    output reg compare_out_pin_oe_o,
    output reg overflow_flag_o,
    output reg compare_match_flag_o
);

// ----------------------------------------------------------------
// register file
// ----------------------------------------------------------------
reg [7:0] ctrl_q;
reg [7:0] count_q;
reg [7:0] cmp_q;
reg [7:0] cmp_buf_q;
reg async_clock_select_q;
reg port_dir_q;
reg blk_q;
reg dir_down_q;
reg wave_q;
reg [PRESC_W-1:0] presc_q;
reg async_s1_q;
reg async_s2_q;
reg async_s3_q;

// both pwm modes have the low mode bit set
function pwm_mode;
    input [1:0] m;
    begin
        pwm_mode = m[0];
    end
endfunction

wire [1:0] waveform_mode_sel = {ctrl_q[`TMW_BIT_WGM1],
                                ctrl_q[`TMW_BIT_WGM0]};
wire [1:0] compare_out_mode = ctrl_q[`TMW_BIT_COM1:`TMW_BIT_COM0];
wire [2:0] clock_prescale_sel = ctrl_q[`TMW_BIT_CS2:`TMW_BIT_CS0];
wire is_pwm = pwm_mode(waveform_mode_sel);
wire wr_ctrl = wr_i && (addr_i == `TMW_OFF_CTRL);
wire wr_count = wr_i && (addr_i == `TMW_OFF_COUNT);
wire wr_cmp = wr_i && (addr_i == `TMW_OFF_CMP);
wire wr_port = wr_i && (addr_i == `TMW_OFF_PORT);

// ----------------------------------------------------------------
// prescaler and timer tick
// ----------------------------------------------------------------
// async clock is sampled and edge detected; it must run well below clk_i
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        async_s1_q <= 1'b0;
        async_s2_q <= 1'b0;
        async_s3_q <= 1'b0;
    end else begin
        async_s1_q <= async_clk_i;
        async_s2_q <= async_s1_q;
        async_s3_q <= async_s2_q;
    end
end

wire src_tick = async_clock_select_q ?
                (async_s2_q && !async_s3_q) : 1'b1;

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        presc_q <= {PRESC_W{1'b0}};
    end else if (clock_prescale_sel == 3'h0) begin
        presc_q <= {PRESC_W{1'b0}};
    end else if (src_tick) begin
        presc_q <= presc_q + {{(PRESC_W-1){1'b0}}, 1'b1};
    end
end

// a divider by 2^n ticks when the low n bits of the prescaler are all ones
function presc_done;
    input [PRESC_W-1:0] p;
    input [3:0] n;
    integer k;
    begin
        presc_done = 1'b1;
        for (k = 0; k < PRESC_W; k = k + 1) begin
            if (k < n && !p[k]) begin
                presc_done = 1'b0;
            end
        end
    end
endfunction

reg tick;
always @* begin
    case (clock_prescale_sel)
    3'h0: tick = 1'b0;
    3'h1: tick = src_tick;
    3'h2: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV8);
    3'h3: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV32);
    3'h4: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV64);
    3'h5: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV128);
    3'h6: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV256);
    default: tick = src_tick && presc_done(presc_q, `TMW_LOG_DIV1024);
    endcase
end

// ----------------------------------------------------------------
// counter, compare and waveform
// ----------------------------------------------------------------
wire [7:0] top = (waveform_mode_sel == `TMW_MODE_CTC) ?
                 cmp_q : `TMW_TOP_MAX;
wire at_top = (count_q == top);
wire raw_match = (count_q == cmp_q) && !blk_q;
// pwm special case: compare equal to top with upper bit set only acts at top
wire match = raw_match && !(is_pwm && cmp_q == `TMW_TOP_MAX &&
                            compare_out_mode[1]);
// a forced compare uses the mode bits written with it, not the old ones
wire [1:0] force_mode = wdata_i[`TMW_BIT_COM1:`TMW_BIT_COM0];
wire force_ev = wr_ctrl && wdata_i[`TMW_BIT_FORCE] &&
                !pwm_mode({wdata_i[`TMW_BIT_WGM1],
                           wdata_i[`TMW_BIT_WGM0]});
// the slope turns at bottom, so a match there counts as an up match;
// this keeps the pin steady when the compare value is zero
wire pc_down = dir_down_q && (count_q != `TMW_BOTTOM);

reg [7:0] count_d;
reg dir_d;
always @* begin
    count_d = count_q;
    dir_d = dir_down_q;
    case (waveform_mode_sel)
    `TMW_MODE_PCPWM: begin
        if (!dir_down_q) begin
            if (count_q == `TMW_TOP_MAX) begin
                dir_d = 1'b1;
                count_d = count_q - 8'h01;
            end else begin
                count_d = count_q + 8'h01;
            end
        end else begin
            if (count_q == `TMW_BOTTOM) begin
                dir_d = 1'b0;
                count_d = count_q + 8'h01;
            end else begin
                count_d = count_q - 8'h01;
            end
        end
    end
    // forced compare never feeds this path, so it cannot clear the count
    `TMW_MODE_CTC: count_d = at_top ? `TMW_BOTTOM : count_q + 8'h01;
    default: count_d = count_q + 8'h01;
    endcase
end

reg wave_d;
always @* begin
    wave_d = wave_q;
    if (force_ev) begin
        case (force_mode)
        2'h1: wave_d = !wave_q;
        2'h2: wave_d = 1'b0;
        2'h3: wave_d = 1'b1;
        default: wave_d = wave_q;
        endcase
    end else if (!is_pwm) begin
        if (tick && match) begin
            case (compare_out_mode)
            2'h1: wave_d = !wave_q;
            2'h2: wave_d = 1'b0;
            2'h3: wave_d = 1'b1;
            default: wave_d = wave_q;
            endcase
        end
    end else if (tick && compare_out_mode[1]) begin
        if (waveform_mode_sel == `TMW_MODE_FPWM) begin
            if (count_q == `TMW_TOP_MAX) begin
                wave_d = !compare_out_mode[0];
            end else if (match) begin
                wave_d = compare_out_mode[0];
            end
        end else begin
            if (match) begin
                wave_d = pc_down ^ compare_out_mode[0];
            end else if (count_q == `TMW_TOP_MAX &&
                         cmp_q == `TMW_TOP_MAX) begin
                wave_d = !compare_out_mode[0];
            end
        end
    end
end

wire cmp_load = is_pwm && tick && count_q == `TMW_TOP_MAX &&
                (waveform_mode_sel == `TMW_MODE_FPWM || !dir_down_q);
wire ovf_point = (waveform_mode_sel == `TMW_MODE_PCPWM) ?
                 (count_q == `TMW_BOTTOM && dir_down_q) :
                 (count_q == `TMW_TOP_MAX);

// ----------------------------------------------------------------
// software visible registers
// ----------------------------------------------------------------
// strobe bit is never stored, so a read can never see it set
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        ctrl_q <= `TMW_CTRL_RST;
    end else if (wr_ctrl) begin
        ctrl_q <= {1'b0, wdata_i[6:0]};
    end
end

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        async_clock_select_q <= 1'b0;
        port_dir_q <= 1'b0;
    end else if (wr_port) begin
        async_clock_select_q <= wdata_i[`TMW_BIT_ASYNC];
        port_dir_q <= wdata_i[`TMW_BIT_DIR];
    end
end

// pwm modes take the buffered value only when the count is at top (0xff),
// which keeps every pwm period free of glitches
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        cmp_buf_q <= 8'h00;
        cmp_q <= 8'h00;
    end else begin
        if (wr_cmp) begin
            cmp_buf_q <= wdata_i;
        end
        if (wr_cmp && !is_pwm) begin
            cmp_q <= wdata_i;
        end else if (cmp_load) begin
            cmp_q <= cmp_buf_q;
        end
    end
end

// ----------------------------------------------------------------
// counter, flags and pin
// ----------------------------------------------------------------
// a counter write wins over the tick of the same cycle and arms the
// one-tick match block
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        count_q <= 8'h00;
        blk_q <= 1'b0;
        dir_down_q <= 1'b0;
    end else if (wr_count) begin
        count_q <= wdata_i;
        blk_q <= 1'b1;
    end else if (tick) begin
        count_q <= count_d;
        dir_down_q <= dir_d;
        blk_q <= 1'b0;
    end
end

always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        wave_q <= 1'b0;
    end else begin
        wave_q <= wave_d;
    end
end

// flags are single-cycle pulses; any sticky latch lives outside
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        overflow_flag_o <= 1'b0;
        compare_match_flag_o <= 1'b0;
    end else begin
        overflow_flag_o <= tick && !wr_count && ovf_point;
        compare_match_flag_o <= tick && !wr_count && raw_match;
    end
end

// the pin falls back to the port value while the output is disconnected
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        compare_out_pin_o <= 1'b0;
        compare_out_pin_oe_o <= 1'b0;
    end else begin
        compare_out_pin_o <= (compare_out_mode != 2'h0) ?
                             wave_d : port_data_i;
        compare_out_pin_oe_o <= port_dir_q;
    end
end

// ----------------------------------------------------------------
// read side
// ----------------------------------------------------------------
always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
        rdata_o <= 8'h00;
    end else if (rd_i) begin
        case (addr_i)
        `TMW_OFF_CTRL: rdata_o <= {1'b0, ctrl_q[6:0]};
        `TMW_OFF_COUNT: rdata_o <= count_q;
        `TMW_OFF_CMP: rdata_o <= is_pwm ? cmp_buf_q : cmp_q;
        `TMW_OFF_PORT: rdata_o <= {6'h00, port_dir_q, async_clock_select_q};
        `TMW_OFF_STAT: rdata_o <= {5'h00, wave_q, dir_down_q, blk_q};
        default: rdata_o <= 8'h00;
        endcase
    end else begin
        rdata_o <= 8'h00;
    end
end

endmodule
`default_nettype wire

// ==== tmw_timer8_monitor.sv ====
// assertion checker for the 8-bit timer ports
`include "tmw_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tmw_timer8_monitor (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic async_clk_i,
    input wire logic [`TMW_ADDR_W-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic port_data_i,
    input wire logic compare_out_pin_o,
    input wire logic compare_out_pin_oe_o,
    input wire logic overflow_flag_o,
    input wire logic compare_match_flag_o
);
    logic [7:0] ctl_q;
    logic [7:0] cmp_q;
    logic [1:0] idle_q;
    wire wctl = wr_i && addr_i == `TMW_OFF_CTRL;
    wire wcnt = wr_i && addr_i == `TMW_OFF_COUNT;
    wire run1 = ctl_q == 8'h01;
    // idle_q lets a late tick of a just-stopped counter settle first
    wire fst = wctl && wdata_i[7] && wdata_i[2:0] == 3'h0 && &idle_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_q <= 8'h00;
            cmp_q <= 8'h00;
            idle_q <= 2'h0;
        end else begin
            if (wctl)
                ctl_q <= {1'b0, wdata_i[6:0]};
            if (wr_i && addr_i == `TMW_OFF_CMP)
                cmp_q <= wdata_i;
            if (ctl_q[2:0] != 3'h0)
                idle_q <= 2'h0;
            else if (idle_q != 2'h3)
                idle_q <= idle_q + 2'h1;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_force_reads_zero: assert property (
        rd_i && addr_i == `TMW_OFF_CTRL |=> !rdata_o[7])
        else $error("force bit read back as one");
    a_force_sets_pin: assert property (
        fst && wdata_i[6:4] == 3'b011 |-> ##2 compare_out_pin_o)
        else $error("forced set not seen on pin");
    a_force_clears_pin: assert property (
        fst && wdata_i[6:4] == 3'b010 |-> ##2 !compare_out_pin_o)
        else $error("forced clear not seen on pin");
    a_force_pwm_none: assert property (
        fst && wdata_i[6] && wdata_i[5] && wdata_i[6:0] == ctl_q[6:0]
        |=> $stable(compare_out_pin_o) [*2])
        else $error("force acted in pwm mode");
    a_force_no_flag: assert property (
        fst |=> !compare_match_flag_o [*3])
        else $error("force raised the match flag");
    a_oe_follows_dir: assert property (
        wr_i && addr_i == `TMW_OFF_PORT
        |=> ##1 compare_out_pin_oe_o == $past(wdata_i[1], 2))
        else $error("output enable differs from direction");
    a_pin_port_off: assert property (
        $past(arst_n_i) && $past(ctl_q[5:4]) == 2'h0
        |-> compare_out_pin_o == $past(port_data_i))
        else $error("pin not port value while disconnected");
    a_ovf_after_max: assert property (
        wcnt && wdata_i == 8'hfe && run1
        |-> ##2 !overflow_flag_o ##1 overflow_flag_o)
        else $error("overflow not at max");
    a_match_blocked: assert property (
        wcnt && wdata_i == cmp_q && run1 |=> !compare_match_flag_o [*3])
        else $error("match after counter write");
    a_match_next: assert property (
        wcnt && wdata_i + 8'h01 == cmp_q && run1
        |-> ##3 compare_match_flag_o)
        else $error("match missed");
    c_force: cover property (fst);
    c_count_write: cover property (wcnt && run1);
    c_overflow: cover property (overflow_flag_o);
endmodule
bind tmw_timer8 tmw_timer8_monitor u_mon (.clk_i(clk_i),
    .arst_n_i(arst_n_i), .async_clk_i(async_clk_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .port_data_i(port_data_i), .compare_out_pin_o(compare_out_pin_o),
    .compare_out_pin_oe_o(compare_out_pin_oe_o),
    .overflow_flag_o(overflow_flag_o),
    .compare_match_flag_o(compare_match_flag_o));
`default_nettype wire

// ==== tmw_timer8_tb_top.sv ====
// self-checking bench for the 8-bit timer
`include "tmw_map.vh"
`timescale 1ns/1ns
`default_nettype none
module tmw_timer8_tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic aclk = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pd = 1'b1;
    logic [7:0] rdata, v, d, q;
    logic pin, oe, ovf, mat;
    int fails = 0;
    int checked = 0;
    int hi;
    int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    always #5 clk_i = ~clk_i;
    always #37 aclk = ~aclk;
    tmw_timer8 u_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .async_clk_i(aclk), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .port_data_i(pd),
        .compare_out_pin_o(pin), .compare_out_pin_oe_o(oe),
        .overflow_flag_o(ovf), .compare_match_flag_o(mat));
    // --------------------------------
    // bus cycles and comparison
    // --------------------------------
    task automatic chk(input [15:0] got, input [15:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input [3:0] a, input [7:0] x);
        @(posedge clk_i);
        wr <= 1'b1;
        addr <= a;
        wdata <= x;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input [3:0] a, output [7:0] x);
        @(posedge clk_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 x = rdata;
    endtask
    // a full period of ones is phase independent
    task automatic duty(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge clk_i);
            #1 h += (pin === 1'b1);
        end
    endtask
    function automatic int exp_hi(input bit fast, input bit inv, int c);
        if (fast)
            return inv ? 255 - c : (c == 255 ? 256 : c + 1);
        return inv ? 510 - 2 * c : 2 * c;
    endfunction
    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        wrap_up();
    end
    // --------------------------------
    // scenarios
    // --------------------------------
    initial begin
        void'($urandom(25));
        repeat (2) @(posedge clk_i);
        arst_n_i <= 1'b1;
        rd_reg(`TMW_OFF_CTRL, d);
        chk(d, 8'h00);
        rd_reg(4'hf, d);
        chk(d, 8'h00);
        wr_reg(`TMW_OFF_PORT, 8'h02);
        v = $urandom;
        wr_reg(`TMW_OFF_COUNT, v);
        repeat (20) @(posedge clk_i);
        chk(oe, 1'b1);
        chk(pin, 1'b1);
        rd_reg(`TMW_OFF_COUNT, d);
        chk(d, v);
        v = $urandom;
        wr_reg(`TMW_OFF_CMP, v);
        rd_reg(`TMW_OFF_CMP, d);
        chk(d, v);
        wr_reg(`TMW_OFF_CTRL, 8'h01);
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 8'hff : i == 1 ? 8'hfe : i == 2 ? v : $urandom;
            d = i == 3 ? v - 8'h01 : d;
            wr_reg(`TMW_OFF_COUNT, d);
            rd_reg(`TMW_OFF_COUNT, q);
            chk(q, 8'(d + 8'h01));
        end
        v = 8'h02 + 8'($urandom_range(252));
        wr_reg(`TMW_OFF_CMP, v);
        wr_reg(`TMW_OFF_CTRL, 8'h09);
        wr_reg(`TMW_OFF_COUNT, v - 8'h01);
        rd_reg(`TMW_OFF_COUNT, d);
        chk(d, v);
        rd_reg(`TMW_OFF_COUNT, d);
        chk(d, 8'h01);
        wr_reg(`TMW_OFF_CTRL, 8'h08);
        wr_reg(`TMW_OFF_COUNT, v);
        repeat (4) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            wr_reg(`TMW_OFF_CTRL, 8'h88 | {2'h0, 2'(8'h67 >> (2 * i)), 4'h0});
            repeat (2) @(posedge clk_i);
            #1 chk(pin, 4'b1001 >> i & 1);
            rd_reg(`TMW_OFF_CTRL, d);
            chk(d[7], 1'b0);
        end
        rd_reg(`TMW_OFF_COUNT, d);
        chk(d, v);
        wr_reg(`TMW_OFF_CTRL, 8'h68);
        repeat (4) @(posedge clk_i);
        d[0] = pin;
        wr_reg(`TMW_OFF_CTRL, 8'he8);
        repeat (3) @(posedge clk_i);
        #1 chk(pin, d[0]);
        for (int t = 0; t < 12; t++) begin
            v = t < 4 ? 8'hff : t < 8 ? 8'h00 : $urandom;
            wr_reg(`TMW_OFF_CTRL, 8'h00);
            wr_reg(`TMW_OFF_CMP, v);
            wr_reg(`TMW_OFF_COUNT, 8'h00);
            wr_reg(`TMW_OFF_CTRL, {2'b01, 1'b1, t[0], t[1], 3'h1});
            repeat (520) @(posedge clk_i);
            duty(t[1] ? 256 : 510, hi);
            chk(hi[15:0], 16'(exp_hi(t[1], t[0], v)));
        end
        for (int s = 2; s < 8; s++) begin
            wr_reg(`TMW_OFF_CTRL, {5'h00, 3'(s)});
            wr_reg(`TMW_OFF_COUNT, 8'h00);
            repeat (dv[s] * 2) @(posedge clk_i);
            rd_reg(`TMW_OFF_COUNT, d);
            chk(d >= 8'h01 && d <= 8'h03, 1'b1);
        end
        wr_reg(`TMW_OFF_CMP, 8'h80);
        wr_reg(`TMW_OFF_PORT, 8'h03);
        wr_reg(`TMW_OFF_CTRL, 8'h01);
        wr_reg(`TMW_OFF_COUNT, 8'h00);
        repeat (148) @(posedge clk_i);
        rd_reg(`TMW_OFF_COUNT, d);
        chk(d >= 8'h12 && d <= 8'h16, 1'b1);
        wrap_up();
    end
endmodule
`default_nettype wire
